// >>> design/isf_pkg.sv
// isf_pkg: shared constants and types of the bus status flag block.
// assumes an 8-bit register port with 20-bit addresses.
package isf_pkg;

  // register addresses
  localparam logic [19:0] ISF_STATUS_ADDR  = 20'hfff56;
  localparam logic [19:0] ISF_CONTROL_ADDR = 20'hfff52;
  localparam logic [7:0]  ISF_STATUS_RESET = 8'h00;

  // bus_control bit positions
  localparam int ISF_CTL_ENABLE_BIT = 7;
  localparam int ISF_CTL_EXIT_BIT   = 6;
  localparam int ISF_CTL_WCANCEL_BIT = 5;

  // address byte handling
  localparam logic [3:0] ISF_EXT_LOW   = 4'h0;
  localparam logic [3:0] ISF_EXT_HIGH  = 4'hf;
  localparam logic [3:0] ISF_LAST_BIT  = 4'h7;
  localparam logic [3:0] ISF_ACK_BIT   = 4'h8;
  localparam logic [3:0] ISF_CNT_ZERO  = 4'h0;
  localparam logic [3:0] ISF_CNT_ONE   = 4'h1;

  // status register, most significant flag first
  typedef struct packed {
    logic master_state_flag;
    logic arbitration_lost_flag;
    logic extension_code_flag;
    logic address_match_flag;
    logic transmit_state_flag;
    logic ack_detected_flag;
    logic start_detected_flag;
    logic stop_detected_flag;
  } isf_status_s;

  // bus events from the shift and timing logic, clk domain pulses
  typedef struct packed {
    logic start_generated;
    logic start_detected;
    logic stop_detected;
    logic arb_lost;
    logic ack_detected;
    logic tx_entered;
    logic ninth_wait;
  } isf_events_s;

  typedef enum logic {
    ISF_L_ADDR,
    ISF_L_DATA
  } isf_link_e;

endpackage : isf_pkg

// >>> design/isf_sync.sv
// isf_sync: two flip-flop level synchroniser.
// assumes the input is a level or a toggle from another clock domain.
`timescale 1ns/100ps
module isf_sync
  import isf_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // clock and reset of the receiving domain
  input  wire logic             clk,
  input  wire logic             rst_n,
  // data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule : isf_sync

// >>> design/isf_status.sv
// isf_status: status flags of the two-wire bus controller.
// assumes bus events arrive as clk pulses from the shift logic and the
// serial clock of the link comes in on link_clk.
`timescale 1ns/100ps
module isf_status
  import isf_pkg::*;
#(
  parameter int ADDR_W = 7
) (
  // system clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // register port
  input  wire logic              reg_rd,
  input  wire logic              reg_wr,
  input  wire logic              reg_bit_op,
  input  wire logic [2:0]        reg_bit_sel,
  input  wire logic [19:0]       reg_addr,
  input  wire logic [7:0]        reg_wdata,
  output logic      [7:0]        reg_rdata,
  // bus events and own address
  input  wire isf_events_s       bus_events,
  input  wire logic [ADDR_W-1:0] own_slave_address,
  // link side
  input  wire logic              link_clk,
  input  wire logic              sda_in,
  // outputs
  output isf_status_s            bus_status,
  output logic                   controller_enable,
  output logic                   sda_oe_n
);

  // register decode
  logic status_hit;
  logic control_wr;
  logic rd_clear;
  logic exit_req;
  logic wait_cancel;
  logic enable_fall;

  // status state
  isf_status_s st_q;
  isf_status_s st_d;
  logic [7:0]  rdata_q;
  logic [7:0]  rdata_d;
  logic        en_q;
  logic        en_d;
  logic        oe_n_q;
  logic        oe_n_d;
  logic        arm_n_q;
  logic        arm_n_d;

  // address capture crossing
  logic        tog_sync;
  logic        tog_seen_q;
  logic        tog_seen_d;
  logic        addr_evt;
  logic        ext_hit;
  logic        match_hit;

  // link domain
  logic        link_rst_n;
  isf_link_e   lstate_q;
  isf_link_e   lstate_d;
  logic [3:0]  lcnt_q;
  logic [3:0]  lcnt_d;
  logic [6:0]  lshift_q;
  logic [6:0]  lshift_d;
  logic [7:0]  lbyte_q;
  logic [7:0]  lbyte_d;
  logic        ltog_q;
  logic        ltog_d;

  function automatic logic is_ext_code(input logic [7:0] b);
    is_ext_code = (b[7:4] == ISF_EXT_LOW) || (b[7:4] == ISF_EXT_HIGH);
  endfunction : is_ext_code

  // register decode; status has no write path at all
  always_comb begin
    status_hit  = reg_rd && (reg_addr == ISF_STATUS_ADDR);
    control_wr  = reg_wr && (reg_addr == ISF_CONTROL_ADDR);
    // every status read clears the loss flag, bit reads of other bits too
    rd_clear    = status_hit;
    exit_req    = control_wr && reg_wdata[ISF_CTL_EXIT_BIT];
    wait_cancel = control_wr && reg_wdata[ISF_CTL_WCANCEL_BIT];
    enable_fall = control_wr && en_q
                  && !reg_wdata[ISF_CTL_ENABLE_BIT];
  end

  // address byte decode, captured byte is stable once the toggle lands
  always_comb begin
    addr_evt   = tog_sync ^ tog_seen_q;
    tog_seen_d = tog_sync;
    ext_hit    = addr_evt && is_ext_code(lbyte_q);
    match_hit  = addr_evt
                 && (lbyte_q[7:1] == own_slave_address);
  end

  // flag next values; hardware set wins over software clear
  always_comb begin
    st_d = st_q;
    st_d.master_state_flag =
      (st_q.master_state_flag
       & ~(bus_events.stop_detected | bus_events.arb_lost
           | exit_req | enable_fall))
      | (bus_events.start_generated & ~bus_events.arb_lost);
    st_d.arbitration_lost_flag =
      (st_q.arbitration_lost_flag & ~(rd_clear | enable_fall))
      | bus_events.arb_lost;
    st_d.extension_code_flag =
      (st_q.extension_code_flag
       & ~(bus_events.start_detected | bus_events.stop_detected
           | exit_req | enable_fall))
      | ext_hit;
    st_d.address_match_flag =
      (st_q.address_match_flag
       & ~(bus_events.start_detected | bus_events.stop_detected
           | exit_req | enable_fall))
      | match_hit;
    st_d.transmit_state_flag =
      (st_q.transmit_state_flag
       & ~(bus_events.stop_detected | bus_events.arb_lost | exit_req
           | enable_fall
           | (wait_cancel & bus_events.ninth_wait)))
      | bus_events.tx_entered;
    st_d.ack_detected_flag =
      (st_q.ack_detected_flag
       & ~(bus_events.start_detected | bus_events.stop_detected
           | enable_fall))
      | bus_events.ack_detected;
    st_d.start_detected_flag =
      (st_q.start_detected_flag
       & ~(bus_events.stop_detected | enable_fall))
      | bus_events.start_detected;
    st_d.stop_detected_flag =
      (st_q.stop_detected_flag
       & ~(bus_events.start_detected | enable_fall))
      | bus_events.stop_detected;
    rdata_d = status_hit ? st_q : rdata_q;
    en_d    = control_wr ? reg_wdata[ISF_CTL_ENABLE_BIT] : en_q;
    // data line released as soon as transmit state ends
    oe_n_d  = ~st_d.transmit_state_flag;
    // one-cycle low pulse re-arms the link bit counter on a start
    arm_n_d = ~bus_events.start_detected;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q       <= ISF_STATUS_RESET;
      rdata_q    <= ISF_STATUS_RESET;
      en_q       <= 1'b0;
      oe_n_q     <= 1'b1;
      arm_n_q    <= 1'b1;
      tog_seen_q <= 1'b0;
    end else begin
      st_q       <= st_d;
      rdata_q    <= rdata_d;
      en_q       <= en_d;
      oe_n_q     <= oe_n_d;
      arm_n_q    <= arm_n_d;
      tog_seen_q <= tog_seen_d;
    end
  end

  isf_sync #(
    .WIDTH(1)
  ) u_tog_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (ltog_q),
    .sync_out (tog_sync)
  );

  // link domain: serial clock stops between frames, so the bit
  // counter is re-armed from the clk side, not by a link edge
  assign link_rst_n = rst_n & arm_n_q;

  always_comb begin
    lstate_d = lstate_q;
    lshift_d = {lshift_q[5:0], sda_in};
    lbyte_d  = lbyte_q;
    ltog_d   = ltog_q;
    lcnt_d   = (lcnt_q == ISF_ACK_BIT) ? ISF_CNT_ZERO
                                       : lcnt_q + ISF_CNT_ONE;
    case (lstate_q)
      ISF_L_ADDR: begin
        // eighth rising edge completes the address byte
        if (lcnt_q == ISF_LAST_BIT) begin
          lbyte_d  = {lshift_q, sda_in};
          ltog_d   = ~ltog_q;
          lstate_d = ISF_L_DATA;
        end
      end
      ISF_L_DATA: begin
        lstate_d = ISF_L_DATA;
      end
      default: begin
        lstate_d = ISF_L_ADDR;
      end
    endcase
  end

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      lstate_q <= ISF_L_ADDR;
      lcnt_q   <= ISF_CNT_ZERO;
      lshift_q <= '0;
    end else begin
      lstate_q <= lstate_d;
      lcnt_q   <= lcnt_d;
      lshift_q <= lshift_d;
    end
  end

  // captured byte and toggle survive a re-arm, reset only by rst_n
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      lbyte_q <= '0;
      ltog_q  <= 1'b0;
    end else begin
      lbyte_q <= lbyte_d;
      ltog_q  <= ltog_d;
    end
  end

  assign bus_status        = st_q;
  assign reg_rdata         = rdata_q;
  assign controller_enable = en_q;
  assign sda_oe_n          = oe_n_q;

  // checks
  // loss, one quiet cycle, then the status read that must report it
  sequence s_loss_then_read;
    bus_events.arb_lost ##1 (!rd_clear && !enable_fall)
    ##1 (status_hit && !bus_events.arb_lost);
  endsequence

  a_reset_zero: assert property (
    @(posedge clk) $rose(rst_n) |-> (st_q == ISF_STATUS_RESET))
    else $error("status not zero after reset");

  a_status_nowrite: assert property (
    @(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr == ISF_STATUS_ADDR && $stable(bus_events)
     && bus_events == '0) |=> (st_q == $past(st_q)))
    else $error("status changed by a write");

  a_master_set: assert property (
    @(posedge clk) disable iff (!rst_n)
    (bus_events.start_generated && !bus_events.arb_lost)
    |=> st_q.master_state_flag)
    else $error("master flag not set on start");

  a_master_clear: assert property (
    @(posedge clk) disable iff (!rst_n)
    ((bus_events.stop_detected || exit_req || enable_fall)
     && !bus_events.start_generated) |=> !st_q.master_state_flag)
    else $error("master flag not cleared");

  a_loss_sets: assert property (
    @(posedge clk) disable iff (!rst_n)
    bus_events.arb_lost |=> (st_q.arbitration_lost_flag
                             && !st_q.master_state_flag))
    else $error("loss flag or master flag wrong");

  a_loss_read: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_loss_then_read |=> (reg_rdata[6] && !st_q.arbitration_lost_flag))
    else $error("loss flag not read then cleared");

  a_bit_read_clears: assert property (
    @(posedge clk) disable iff (!rst_n)
    (status_hit && reg_bit_op && reg_bit_sel != 3'h6
     && !bus_events.arb_lost) |=> !st_q.arbitration_lost_flag)
    else $error("bit read left loss flag set");

  a_ext_set: assert property (
    @(posedge clk) disable iff (!rst_n)
    (addr_evt && is_ext_code(lbyte_q)) |=> st_q.extension_code_flag)
    else $error("extension flag not set");

  a_match_set: assert property (
    @(posedge clk) disable iff (!rst_n)
    $changed(tog_sync) && (lbyte_q[7:1] == own_slave_address)
    |=> st_q.address_match_flag)
    else $error("match flag not set");

  a_addr_clear: assert property (
    @(posedge clk) disable iff (!rst_n)
    (bus_events.start_detected && !addr_evt)
    |=> !(st_q.extension_code_flag || st_q.address_match_flag))
    else $error("address flags not cleared on start");

  a_tx_release: assert property (
    @(posedge clk) disable iff (!rst_n)
    (wait_cancel && bus_events.ninth_wait && !bus_events.tx_entered)
    |=> (!st_q.transmit_state_flag && sda_oe_n))
    else $error("wait cancel did not release data line");

  a_enable_bit: assert property (
    @(posedge clk) disable iff (!rst_n)
    control_wr |=> (controller_enable
                    == $past(reg_wdata[ISF_CTL_ENABLE_BIT])))
    else $error("enable bit not taken from bit 7");

endmodule : isf_status

// >>> testbench/isf_link_model.sv
// isf_link_model: far-side master clocking one address byte onto the link.
// assumes start_detected was pulsed at least two clk cycles before a byte.
`timescale 1ns/100ps
module isf_link_model (
  // link pins
  output logic link_clk,
  output logic sda_in
);
  initial begin
    link_clk = 1'b0;
    sda_in   = 1'b1;
  end

  // clock stands still between frames; the released line floats up to
  // the pull-up level
  task automatic send_byte(input logic [7:0] b);
    for (int i = 8; i >= 0; i--) begin
      sda_in = (i > 0) ? b[i-1] : 1'b0;
      #40 link_clk = 1'b1;
      #80 link_clk = 1'b0;
      #40;
    end
    sda_in = 1'b1;
  endtask : send_byte
endmodule : isf_link_model

// >>> testbench/tb_i2c_status_flags.sv
// tb_i2c_status_flags: self-checking bench of the bus status flags.
// assumes isf_pkg, isf_status and isf_link_model are compiled first.
`timescale 1ns/100ps
module tb_i2c_status_flags;
  import isf_pkg::*;
  logic        clk;
  logic        rst_n;
  logic        reg_rd;
  logic        reg_wr;
  logic        reg_bit_op;
  logic [2:0]  reg_bit_sel;
  logic [19:0] reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  isf_events_s bus_events;
  logic [6:0]  own;
  isf_status_s bus_status;
  logic        controller_enable;
  logic        sda_oe_n;
  logic        link_clk;
  logic        sda_in;
  logic [7:0]  b;
  int          failures = 0;
  int          n_compared = 0;
  int          cyc = 0;

  isf_status #(.ADDR_W(7)) isf_status_inst (
    .clk(clk), .rst_n(rst_n), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_bit_op(reg_bit_op), .reg_bit_sel(reg_bit_sel),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .bus_events(bus_events), .own_slave_address(own),
    .link_clk(link_clk), .sda_in(sda_in), .bus_status(bus_status),
    .controller_enable(controller_enable), .sda_oe_n(sda_oe_n));
  isf_link_model isf_link_model_inst (.link_clk(link_clk), .sda_in(sda_in));

  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      wrap_up();
    end
  end

  function automatic logic ext_exp(input logic [7:0] a);
    return (a[7:4] == ISF_EXT_LOW) || (a[7:4] == ISF_EXT_HIGH);
  endfunction : ext_exp

  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(input string nm, input logic [7:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one-cycle event pulses; the ninth_wait level is kept
  task automatic ev(input isf_events_s e);
    bus_events = e;
    tick();
    bus_events = e & 7'h01;
    tick();
  endtask : ev

  // byte or single-bit access only, never wider
  task automatic acc(input logic w, input logic [19:0] a,
                     input logic [7:0] d, input logic bo);
    reg_rd      = ~w;
    reg_wr      = w;
    reg_addr    = a;
    reg_wdata   = d;
    reg_bit_op  = bo;
    reg_bit_sel = 3'($urandom_range(0, 5));
    tick();
    reg_rd     = 1'b0;
    reg_wr     = 1'b0;
    reg_bit_op = 1'b0;
    tick();
  endtask : acc

  task automatic wrap_up();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_bit_op = 1'b0;
    reg_bit_sel = 3'h0;
    reg_addr = 20'h00000;
    reg_wdata = 8'h00;
    bus_events = '0;
    own = 7'($urandom(32'he0625160));
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    chk("status", bus_status, ISF_STATUS_RESET);
    chk("oe_n", 8'(sda_oe_n), 8'h01);
    acc(1'b1, ISF_CONTROL_ADDR, 8'h80, 1'b0);
    chk("enable", 8'(controller_enable), 8'h01);
    // master flag cleared by stop, exit and disable in turn
    for (int k = 0; k < 3; k++) begin
      ev(7'h40);
      chk("master_set", 8'(bus_status[7]), 8'h01);
      if (k == 0) ev(7'h10);
      else acc(1'b1, ISF_CONTROL_ADDR, (k == 1) ? 8'hc0 : 8'h00, 1'b0);
      chk("master_clr", 8'(bus_status[7]), 8'h00);
      acc(1'b1, ISF_CONTROL_ADDR, 8'h80, 1'b0);
    end
    ev(7'h40);
    ev(7'h08);
    chk("arb", 8'(bus_status[7:6]), 8'h01);
    acc(1'b0, ISF_STATUS_ADDR, 8'h00, 1'b0);
    chk("rdata", 8'(reg_rdata[7:6]), 8'h01);
    chk("arb_rd", 8'(bus_status[6]), 8'h00);
    ev(7'h08);
    acc(1'b0, ISF_STATUS_ADDR, 8'h00, 1'b1);
    chk("arb_bit", 8'(bus_status[6]), 8'h00);
    ev(7'h08);
    acc(1'b0, 20'hfff00, 8'h00, 1'b0);
    chk("arb_unmapped", 8'(bus_status[6]), 8'h01);
    b = bus_status;
    acc(1'b1, ISF_STATUS_ADDR, 8'hff, 1'b0);
    chk("status_wr", bus_status, b);
    acc(1'b1, ISF_CONTROL_ADDR, 8'h00, 1'b0);
    chk("arb_dis", 8'(bus_status[6]), 8'h00);
    acc(1'b1, ISF_CONTROL_ADDR, 8'h80, 1'b0);
    // nibble boundaries and own address first, then random bytes
    for (int k = 0; k < 10; k++) begin
      b = (k == 0) ? 8'h0a : (k == 1) ? 8'hf1 : (k == 2) ? {own, 1'b1} :
          (k == 3) ? 8'h1f : (k == 4) ? 8'he0 : 8'($urandom);
      ev(7'h20);
      chk("start_clr", 8'(bus_status[5:4]), 8'h00);
      isf_link_model_inst.send_byte(b);
      tick(6);
      chk("ext", 8'(bus_status[5]), 8'(ext_exp(b)));
      chk("match", 8'(bus_status[4]), 8'(b[7:1] == own));
      if (k % 3 == 1) ev(7'h10);
      if (k % 3 == 2) acc(1'b1, ISF_CONTROL_ADDR, 8'hc0, 1'b0);
      if (k % 3 != 0) chk("clr", 8'(bus_status[5:4]), 8'h00);
    end
    ev(7'h02);
    chk("tx_set", 8'({bus_status[3], sda_oe_n}), 8'h02);
    ev(7'h01);
    acc(1'b1, ISF_CONTROL_ADDR, 8'ha0, 1'b0);
    tick();
    chk("tx_clr", 8'({bus_status[3], sda_oe_n}), 8'h01);
    // mid-run reset with flags standing must clear them all
    ev(7'h08);
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    chk("status_rst", bus_status, ISF_STATUS_RESET);
    chk("rdata_rst", reg_rdata, ISF_STATUS_RESET);
    chk("enable_rst", 8'(controller_enable), 8'h00);
    wrap_up();
  end
endmodule : tb_i2c_status_flags
